/* File: geom_defs.svh */
// Offsets, field positions and timing constants of the geometry bank
`ifndef GEOM_DEFS_SVH
`define GEOM_DEFS_SVH

// ---------------------------------------------------------------
// Byte indices of the bank (byte address = 4 * index)
// ---------------------------------------------------------------
`define IDX_SECURE_PROTECT_INFO   8'hD3
`define IDX_SECTOR_COUNT          8'hD4
`define IDX_SLEEP_NOTIFY_TIMEOUT  8'hD8
`define IDX_SLEEP_AWAKE_TIMEOUT   8'hD9
`define IDX_PROD_STATE_TIMEOUT    8'hDA
`define IDX_IO_SLEEP_CURRENT      8'hDB
`define IDX_CORE_SLEEP_CURRENT    8'hDC
`define IDX_HC_PROTECT_GROUP_SIZE 8'hDD
`define IDX_RELIABLE_WRITE_COUNT  8'hDE
`define IDX_ERASE_TIMEOUT_MULT    8'hDF
`define IDX_HC_ERASE_UNIT_SIZE    8'hE0
`define IDX_ACCESS_GRANULARITY    8'hE1
`define IDX_GROUP_DEF_CTRL        8'hAF
// Derived read-only words, placed after the bank
`define IDX_ERASE_UNIT_KB         8'hF0
`define IDX_PROTECT_GROUP_KB      8'hF1
`define IDX_DENSITY_LO            8'hF2
`define IDX_DENSITY_HI            8'hF3
`define IDX_SUPER_PAGE_BYTES      8'hF4
`define IDX_SLEEP_CURRENT_UA      8'hF5

// ---------------------------------------------------------------
// Field limits and positions
// ---------------------------------------------------------------
`define SUPER_PAGE_MAX            4'h8
`define SLEEP_CURRENT_MAX         8'h0D
`define TIMEOUT_EXP_MAX           8'h17
`define RELIABLE_WRITE_VALUE      8'h01
`define SECURE_SUPPORT_BIT        0
`define SECURE_ENABLE_BIT         1
`define GROUP_DEF_ENABLE_BIT      0
`define SECTOR_BYTES_LOG2         9
`define UNIT_KB                   32'h0000_0200
`define SUPER_PAGE_BASE           32'h0000_0200
`define SLEEP_CURRENT_BASE_UA     32'h0000_0001

// ---------------------------------------------------------------
// Timing bases (erase base in ms, others in ns / us)
// ---------------------------------------------------------------
`define ERASE_BASE_MS             300
`define PROD_BASE_US              100
`define SLEEP_AWAKE_BASE_NS       100
`define NOTIFY_BASE_US            10
`define CLK_PERIOD_NS             10
`define ERASE_BASE_CYC  (`ERASE_BASE_MS * 1000000 / `CLK_PERIOD_NS)
`define PROD_BASE_CYC   (`PROD_BASE_US * 1000 / `CLK_PERIOD_NS)
`define SA_BASE_CYC     (`SLEEP_AWAKE_BASE_NS / `CLK_PERIOD_NS)
`define NOTIFY_BASE_CYC (`NOTIFY_BASE_US * 1000 / `CLK_PERIOD_NS)

`endif

/* File: geom_pkg.sv */
// Types shared by the geometry property bank
package geom_pkg;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_t;

   typedef enum logic [1:0] {
      OP_ERASE,
      OP_PROD,
      OP_SLEEP,
      OP_NOTIFY
   } op_kind_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_BUSY,
      ST_DONE
   } op_state_t;

   typedef struct packed {
      logic        start;
      op_kind_t    kind;
      logic [7:0]  groups;
   } op_req_t;

   typedef struct packed {
      logic [7:0]  access_granularity;
      logic [7:0]  hc_erase_unit_size;
      logic [7:0]  erase_timeout_multiplier;
      logic [7:0]  hc_protect_group_size;
      logic [7:0]  core_sleep_current;
      logic [7:0]  io_sleep_current;
      logic [7:0]  prod_state_timeout;
      logic [7:0]  sleep_awake_timeout;
      logic [7:0]  sleep_notify_timeout;
      logic        secure_support;
   } geom_cfg_t;

endpackage

/* File: extcsd_geometry_timeout_fields.sv */
// Geometry and timeout property bank with APB access, read-only except the group definition word
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "geom_defs.svh"

module extcsd_geometry_timeout_fields
   import geom_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire geom_cfg_t   cfg,
   input  wire logic        secure_enable,
   input  wire logic        partition_done,
   input  wire logic [31:0] user_area_sectors,
   input  wire op_req_t     op_req,
   output logic             op_busy,
   output logic             op_done,
   output logic             legacy_erase,
   output logic             legacy_protect
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic [7:0]  group_def;
      logic [31:0] sector_count;
      op_state_t   st;
      logic [47:0] cnt;
      logic        op_busy;
      logic        op_done;
      logic        legacy_erase;
      logic        legacy_protect;
      op_kind_t    kind;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Exponent clamped at the largest defined code so that a
   // reserved value never yields a wrapped, too-short timeout
   function automatic logic [47:0] pow_time(input logic [31:0] base,
                                            input logic [7:0]  e);
      logic [7:0] ec;
      ec = (e > `TIMEOUT_EXP_MAX) ? `TIMEOUT_EXP_MAX : e;
      pow_time = {16'h0000, base} << ec[4:0];
   endfunction

   function automatic logic [31:0] byte_word(input logic [7:0] b);
      byte_word = {24'h000000, b};
   endfunction

   // ------------------------------------------------------------
   // Derived values
   // ------------------------------------------------------------
   logic [3:0]  sp_code;
   logic [31:0] super_page_bytes;
   logic [31:0] erase_unit_kb;
   logic [31:0] protect_group_kb;
   logic [40:0] density;
   logic [31:0] sleep_current_ua;
   logic [7:0]  info_byte;
   logic        hc_enable;

   always_comb begin
      sp_code = cfg.access_granularity[3:0];
      // Zero and reserved codes report no size
      if (sp_code == 4'h0 || sp_code > `SUPER_PAGE_MAX) begin
         super_page_bytes = 32'h0000_0000;
      end else begin
         super_page_bytes = `SUPER_PAGE_BASE << (sp_code - 4'h1);
      end
      erase_unit_kb = `UNIT_KB * byte_word(cfg.hc_erase_unit_size);
      hc_enable = s_r.group_def[`GROUP_DEF_ENABLE_BIT]
                  && (cfg.hc_erase_unit_size != 8'h00);
      if (!hc_enable || cfg.hc_protect_group_size == 8'h00) begin
         protect_group_kb = 32'h0000_0000;
      end else begin
         protect_group_kb = erase_unit_kb
                            * byte_word(cfg.hc_protect_group_size);
      end
      density = {s_r.sector_count, 9'h000};
      if (cfg.core_sleep_current == 8'h00
          || cfg.core_sleep_current > `SLEEP_CURRENT_MAX) begin
         sleep_current_ua = 32'h0000_0000;
      end else begin
         sleep_current_ua = `SLEEP_CURRENT_BASE_UA
                            << cfg.core_sleep_current[3:0];
      end
      info_byte = 8'h00;
      info_byte[`SECURE_SUPPORT_BIT] = cfg.secure_support;
      info_byte[`SECURE_ENABLE_BIT]  = secure_enable;
   end

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   function automatic logic [31:0] read_word(input logic [9:0] idx);
      case (idx)
         10'(`IDX_SECURE_PROTECT_INFO):   read_word = byte_word(info_byte);
         10'(`IDX_SECTOR_COUNT):          read_word = s_r.sector_count;
         10'(`IDX_SLEEP_NOTIFY_TIMEOUT):
            read_word = byte_word(cfg.sleep_notify_timeout);
         10'(`IDX_SLEEP_AWAKE_TIMEOUT):
            read_word = byte_word(cfg.sleep_awake_timeout);
         10'(`IDX_PROD_STATE_TIMEOUT):
            read_word = byte_word(cfg.prod_state_timeout);
         10'(`IDX_IO_SLEEP_CURRENT):
            read_word = byte_word(cfg.io_sleep_current);
         10'(`IDX_CORE_SLEEP_CURRENT):
            read_word = byte_word(cfg.core_sleep_current);
         10'(`IDX_HC_PROTECT_GROUP_SIZE):
            read_word = byte_word(cfg.hc_protect_group_size);
         10'(`IDX_RELIABLE_WRITE_COUNT):
            read_word = byte_word(`RELIABLE_WRITE_VALUE);
         10'(`IDX_ERASE_TIMEOUT_MULT):
            read_word = byte_word(cfg.erase_timeout_multiplier);
         10'(`IDX_HC_ERASE_UNIT_SIZE):
            read_word = byte_word(cfg.hc_erase_unit_size);
         10'(`IDX_ACCESS_GRANULARITY):
            read_word = byte_word({4'h0, cfg.access_granularity[3:0]});
         10'(`IDX_GROUP_DEF_CTRL):        read_word = byte_word(s_r.group_def);
         10'(`IDX_ERASE_UNIT_KB):         read_word = erase_unit_kb;
         10'(`IDX_PROTECT_GROUP_KB):      read_word = protect_group_kb;
         10'(`IDX_DENSITY_LO):            read_word = density[31:0];
         10'(`IDX_DENSITY_HI):            read_word = {23'h000000, density[40:32]};
         10'(`IDX_SUPER_PAGE_BYTES):      read_word = super_page_bytes;
         10'(`IDX_SLEEP_CURRENT_UA):      read_word = sleep_current_ua;
         default:                         read_word = 32'h0000_0000;
      endcase
   endfunction

   function automatic logic mapped(input logic [9:0] idx);
      mapped = (idx == 10'(`IDX_GROUP_DEF_CTRL))
               || (idx >= 10'(`IDX_SECURE_PROTECT_INFO)
                   && idx <= 10'(`IDX_ACCESS_GRANULARITY))
               || (idx >= 10'(`IDX_ERASE_UNIT_KB)
                   && idx <= 10'(`IDX_SLEEP_CURRENT_UA));
   endfunction

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   logic [9:0]  idx;
   logic        setup;
   logic        aligned;
   logic [47:0] limit;

   always_comb begin
      s_nxt = s_r;
      idx   = paddr[11:2];
      setup = psel && !penable;
      aligned = (paddr[1:0] == 2'b00);
      limit = 48'h0;
      s_nxt.pready = 1'b0;
      s_nxt.op_done = 1'b0;
      // No wait state: answer registered in the setup phase, shown in the access phase
      if (setup) begin
         s_nxt.pready  = 1'b1;
         s_nxt.pslverr = !mapped(idx) || !aligned;
         // A misaligned access neither returns data nor lands a write
         s_nxt.prdata  = (pwrite || !aligned) ? 32'h0000_0000
                                              : read_word(idx);
         if (pwrite && aligned && idx == 10'(`IDX_GROUP_DEF_CTRL)) begin
            s_nxt.group_def = {7'h00, pwdata[`GROUP_DEF_ENABLE_BIT]};
         end
         // Writes elsewhere in the bank are dropped, flagged as error
         if (pwrite && idx != 10'(`IDX_GROUP_DEF_CTRL)) begin
            s_nxt.pslverr = 1'b1;
         end
      end
      if (partition_done) begin
         s_nxt.sector_count = user_area_sectors;
      end
      s_nxt.legacy_erase = !s_r.group_def[`GROUP_DEF_ENABLE_BIT]
                           || cfg.erase_timeout_multiplier == 8'h00;
      s_nxt.legacy_protect = !hc_enable
                             || cfg.hc_protect_group_size == 8'h00;
      // Busy and done cycles together fit inside each advertised bound
      case (s_r.kind)
         OP_ERASE:  limit = 48'(`ERASE_BASE_CYC) - 48'h2;
         OP_PROD:   limit = pow_time(`PROD_BASE_CYC,
                               cfg.prod_state_timeout) - 48'h2;
         OP_SLEEP:  limit = pow_time(`SA_BASE_CYC,
                               cfg.sleep_awake_timeout) - 48'h2;
         OP_NOTIFY: limit = pow_time(`NOTIFY_BASE_CYC,
                               cfg.sleep_notify_timeout) - 48'h2;
         default:   limit = 48'h0;
      endcase
      case (s_r.st)
         ST_IDLE: begin
            if (op_req.start) begin
               s_nxt.st = ST_BUSY;
               // Kind is held so a moving request cannot bend the count
               s_nxt.kind = op_req.kind;
               s_nxt.op_busy = 1'b1;
               s_nxt.cnt = 48'h0;
            end
         end
         ST_BUSY: begin
            s_nxt.cnt = s_r.cnt + 48'h1;
            if (s_r.cnt >= limit) begin
               s_nxt.st = ST_DONE;
            end
         end
         ST_DONE: begin
            s_nxt.op_busy = 1'b0;
            s_nxt.op_done = 1'b1;
            s_nxt.st = ST_IDLE;
         end
         default: s_nxt.st = ST_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '{prdata: 32'h0, pready: 1'b0, pslverr: 1'b0,
                  group_def: 8'h00, sector_count: 32'h0,
                  st: ST_IDLE, cnt: 48'h0, op_busy: 1'b0,
                  op_done: 1'b0, legacy_erase: 1'b1,
                  legacy_protect: 1'b1, kind: OP_ERASE};
      end else if (clk_en) begin
         s_r <= s_nxt;
      end
   end

   assign prdata         = s_r.prdata;
   assign pready         = s_r.pready;
   assign pslverr        = s_r.pslverr;
   assign op_busy        = s_r.op_busy;
   assign op_done        = s_r.op_done;
   assign legacy_erase   = s_r.legacy_erase;
   assign legacy_protect = s_r.legacy_protect;

endmodule // extcsd_geometry_timeout_fields

/* File: extcsd_geometry_timeout_fields_sva.sv */
// Port assertions for the geometry property bank
`timescale 1ns/1ps
module geom_bank_checker
   import geom_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        clk_en,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire geom_cfg_t   cfg,
   input wire logic        secure_enable,
   input wire op_req_t     op_req,
   input wire logic        op_busy,
   input wire logic        op_done,
   input wire logic        legacy_erase,
   input wire logic        legacy_protect
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic setup;
   assign setup = psel && !penable && clk_en;
   // ---------------------------------------------------------
   // Bus answer
   // ---------------------------------------------------------
   answer_next_a: assert property (setup |=> pready)
      else $error("no answer after setup");
   ready_pulse_a: assert property (pready && clk_en |=> !pready)
      else $error("ready longer than one cycle");
   write_refused_a: assert property (
      setup && pwrite && paddr != 12'h2BC |=> pslverr)
      else $error("bank write not refused");
   // ---------------------------------------------------------
   // Field contents
   // ---------------------------------------------------------
   misaligned_err_a: assert property (
      setup && paddr[1:0] != 2'b00 |=> pslverr && prdata == 32'h0000_0000)
      else $error("misaligned access not refused");
   relcount_read_a: assert property (
      setup && !pwrite && paddr == 12'h378 |=> prdata == 32'h0000_0001)
      else $error("reliable count not one");
   info_bits_a: assert property (setup && !pwrite && paddr == 12'h34C
      |=> prdata == {30'h0, $past(secure_enable), $past(cfg.secure_support)})
      else $error("protect info bits wrong");
   page_nibble_a: assert property (setup && !pwrite && paddr == 12'h384
      |=> prdata == {28'h0, $past(cfg.access_granularity[3:0])})
      else $error("access size not low nibble");
   legacy_erase_a: assert property (
      clk_en && cfg.erase_timeout_multiplier == 8'h00 |=> legacy_erase)
      else $error("zero multiplier not legacy");
   legacy_prot_a: assert property (
      clk_en && cfg.hc_protect_group_size == 8'h00 |=> legacy_protect)
      else $error("zero group not legacy");
   // Only sleep exponent 1 is bounded here; longer ones need counters
   sleep_time_a: assert property (clk_en && op_req.start && !op_busy
      && !op_done && op_req.kind == OP_SLEEP
      && cfg.sleep_awake_timeout == 8'h01 |=> op_busy ##[0:20] op_done)
      else $error("sleep transition too slow");
   cover property (setup && pwrite);
   cover property (pready && pslverr);
   cover property (op_done);
endmodule // geom_bank_checker

bind extcsd_geometry_timeout_fields geom_bank_checker chk (
   .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .prdata,
   .pready, .pslverr, .cfg, .secure_enable, .op_req, .op_busy, .op_done,
   .legacy_erase, .legacy_protect);

/* File: geom_host.sv */
// Host-side bus master issuing one transfer per go request
`timescale 1ns/1ps
module geom_host
   import geom_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        go,
   input  wire logic        wr,
   input  wire logic [11:0] addr,
   input  wire logic [31:0] wdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output apb_req_t         req,
   output logic [31:0]      rdata,
   output logic             err,
   output logic             done
);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req   <= '0;
         rdata <= '0;
         err   <= 1'b0;
         done  <= 1'b0;
      end else begin
         done <= 1'b0;
         if (req.psel && req.penable && pready) begin
            rdata       <= prdata;
            err         <= pslverr;
            done        <= 1'b1;
            req.psel    <= 1'b0;
            req.penable <= 1'b0;
            // Released address and data lines flip so stale values never look valid
            req.paddr   <= ~req.paddr;
            req.pwdata  <= ~req.pwdata;
         end else if (req.psel)
            req.penable <= 1'b1;
         else if (go)
            req <= '{1'b1, 1'b0, wr, addr, wdata};
      end
   end
endmodule // geom_host

/* File: test_extcsd_geometry_timeout_fields.sv */
// Self-checking bench for the geometry property bank
`timescale 1ns/1ps
module test_extcsd_geometry_timeout_fields;
   import geom_pkg::*;
   logic        pclk, presetn, clk_en, go, wr, done, err, gdef;
   logic        secure_enable, partition_done, op_busy, op_done;
   logic        legacy_erase, legacy_protect, pready, pslverr;
   logic [11:0] addr;
   logic [31:0] wdata, rdata, prdata, sectors, user_area_sectors;
   logic [95:0] r;
   apb_req_t    req;
   geom_cfg_t   cfg;
   op_req_t     op_req;
   op_kind_t    kinds [3] = '{OP_SLEEP, OP_NOTIFY, OP_PROD};
   logic [9:0]  idx [21] = '{10'h0AF, 10'h0D3, 10'h0D4, 10'h0D8, 10'h0D9,
      10'h0DA, 10'h0DB, 10'h0DC, 10'h0DD, 10'h0DE, 10'h0DF, 10'h0E0,
      10'h0E1, 10'h0F0, 10'h0F1, 10'h0F2, 10'h0F3, 10'h0F4, 10'h0F5,
      10'h050, 10'h3FF};
   int          fail_count, check_count, seed, n, lim;

   extcsd_geometry_timeout_fields uut (.pclk, .presetn, .clk_en,
      .psel(req.psel), .penable(req.penable), .pwrite(req.pwrite),
      .paddr(req.paddr), .pwdata(req.pwdata), .prdata, .pready, .pslverr,
      .cfg, .secure_enable, .partition_done, .user_area_sectors, .op_req,
      .op_busy, .op_done, .legacy_erase, .legacy_protect);
   geom_host host (.pclk, .presetn, .go, .wr, .addr, .wdata, .prdata,
      .pready, .pslverr, .req, .rdata, .err, .done);

   always #5 pclk = ~pclk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   function automatic logic [31:0] expw(input logic [9:0] i);
      logic [40:0] dn;
      logic [3:0]  sp;
      logic [7:0]  cs;
      dn = {9'h000, sectors} << 9;
      sp = cfg.access_granularity[3:0];
      cs = cfg.core_sleep_current;
      case (i)
         10'h0AF: return {31'h0, gdef};
         10'h0D3: return {30'h0, secure_enable, cfg.secure_support};
         10'h0D4: return sectors;
         10'h0D8: return {24'h0, cfg.sleep_notify_timeout};
         10'h0D9: return {24'h0, cfg.sleep_awake_timeout};
         10'h0DA: return {24'h0, cfg.prod_state_timeout};
         10'h0DB: return {24'h0, cfg.io_sleep_current};
         10'h0DC: return {24'h0, cs};
         10'h0DD: return {24'h0, cfg.hc_protect_group_size};
         10'h0DE: return 32'h0000_0001;
         10'h0DF: return {24'h0, cfg.erase_timeout_multiplier};
         10'h0E0: return {24'h0, cfg.hc_erase_unit_size};
         10'h0E1: return {28'h0, sp};
         10'h0F0: return 32'h0000_0200 * cfg.hc_erase_unit_size;
         10'h0F1: return (!gdef || cfg.hc_protect_group_size == 8'h00) ? 0
            : 32'h0000_0200 * cfg.hc_erase_unit_size
              * cfg.hc_protect_group_size;
         10'h0F2: return dn[31:0];
         10'h0F3: return {23'h0, dn[40:32]};
         10'h0F4: return (sp inside {[1:8]}) ? 32'h200 << (sp - 1) : 0;
         10'h0F5: return (cs inside {[1:13]}) ? 32'h1 << cs : 0;
         default: return 32'h0;
      endcase
   endfunction

   // One transfer through the host model, then judge answer and data
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
      logic bad;
      bad = (a[1:0] != 2'b00) || (w && a != 12'h2BC);
      foreach (idx[k])
         bad = bad | (k > 18 && idx[k] == a[11:2]);
      go    <= 1'b1;
      wr    <= w;
      addr  <= a;
      wdata <= d;
      @(posedge pclk);
      go <= 1'b0;
      for (n = 0; n < 50 && !done; n++)
         @(posedge pclk);
      check({31'h0, done}, 32'h1);
      check({31'h0, err}, {31'h0, bad});
      if (!w)
         check(rdata, a[1:0] != 2'b00 ? 32'h0 : expw(a[11:2]));
      if (w && a == 12'h2BC)
         gdef = d[0];
   endtask

   initial begin
      {pclk, presetn, go, wr, gdef, secure_enable, partition_done} = '0;
      {addr, wdata, sectors, user_area_sectors, r} = '0;
      cfg = '0;
      op_req = '0;
      clk_en = 1'b1;
      seed = 64;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      xfer(1'b0, 12'h350, 32'h0);
      user_area_sectors <= 32'hFFFF_FFFF;
      partition_done <= 1'b1;
      @(posedge pclk);
      partition_done <= 1'b0;
      sectors = 32'hFFFF_FFFF;
      xfer(1'b1, 12'h350, 32'h0000_1234);
      xfer(1'b0, 12'h350, 32'h0);
      xfer(1'b0, 12'h3CC, 32'h0);
      xfer(1'b0, 12'h351, 32'h0);
      xfer(1'b1, 12'h2BC, 32'h0000_0001);
      for (int t = 0; t < 60; t++) begin
         r = {$random(seed), $random(seed), $random(seed)};
         if (r[86]) begin
            user_area_sectors <= r[63:32];
            partition_done <= 1'b1;
            @(posedge pclk);
            partition_done <= 1'b0;
            sectors = r[63:32];
         end
         cfg <= r[72:0];
         secure_enable <= r[80];
         @(posedge pclk);
         xfer(r[84] & r[83], {idx[r[95:91] % 21], r[82] & r[81], r[79]
            & r[78]}, r[31:0]);
         repeat (2) @(posedge pclk);
         check({30'h0, legacy_erase, legacy_protect}, {30'h0,
            !gdef || !cfg.erase_timeout_multiplier,
            !gdef || !cfg.hc_erase_unit_size
            || !cfg.hc_protect_group_size});
      end
      cfg.sleep_awake_timeout <= 8'h01;
      cfg.prod_state_timeout <= 8'h01;
      cfg.sleep_notify_timeout <= 8'h01;
      foreach (kinds[k]) begin
         lim = kinds[k] == OP_SLEEP ? 20 : kinds[k] == OP_PROD ? 20000 : 2000;
         op_req <= '{1'b1, kinds[k], r[7:0]};
         @(posedge pclk);
         op_req.start <= 1'b0;
         // Freezing the enable must stretch the longer waits
         clk_en <= (kinds[k] == OP_SLEEP);
         repeat (5) @(posedge pclk);
         clk_en <= 1'b1;
         for (n = kinds[k] == OP_SLEEP ? 5 : 0; n < lim + 9 && !op_done; n++)
            @(posedge pclk);
         check(32'(n <= lim + 2), 32'h1);
         repeat (3) @(posedge pclk);
      end
      op_req <= '{1'b1, OP_ERASE, 8'h02};
      @(posedge pclk);
      op_req.start <= 1'b0;
      repeat (4) @(posedge pclk);
      check({31'h0, op_busy}, 32'h1);
      presetn <= 1'b0;
      @(posedge pclk);
      check({30'h0, op_busy, legacy_erase}, 32'h1);
      presetn <= 1'b1;
      {gdef, sectors} = '0;
      @(posedge pclk);
      xfer(1'b0, 12'h350, 32'h0);
      tally_and_finish();
   end

   initial begin
      #1_000_000;
      fail_count++;
      tally_and_finish();
   end
endmodule // test_extcsd_geometry_timeout_fields
